// *** hdl/osw_ctrl.sv ***
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
module osw_ctrl #(
  parameter int SETTLE = osw_pkg::SETTLE_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [osw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire osw_pkg::osw_cfg_s cfg_pins,
  input wire osw_pkg::osw_stat_s osc_status,
  input wire logic irq_event,
  output osw_pkg::osw_ctl_s osc_ctl
);
  import osw_pkg::*;

  // pins and analog status are asynchronous
  logic [15:0] sync1_reg;
  logic [15:0] sync2_reg;
  logic tick_d_reg;
  logic [1:0] init_cnt_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  osw_unlock_e unl_hi_reg;
  osw_unlock_e unl_lo_reg;
  logic [2:0] active_reg;
  logic [2:0] requested_reg;
  logic sel_lock_reg;
  logic pll_lock_reg;
  logic fail_reg;
  logic secondary_osc_en_reg;
  logic sw_req_reg;
  logic roi_reg;
  logic [2:0] doze_ratio_reg;
  logic doze_act_reg;
  logic [2:0] post_reg;
  logic [5:0] trim_reg;
  osw_oscmask_t osc_en_reg;
  logic pll_en_reg;
  logic [1:0] submode_reg;
  logic [2:0] ratio_out_reg;
  logic cpu_en_reg;
  logic [6:0] div_cnt_reg;
  logic sw_busy;
  logic sw_begin;
  logic sw_abort;
  logic sw_done;

  wire osw_cfg_s cfg_sync = osw_cfg_s'(sync2_reg[15:9]);
  wire osw_stat_s stat_sync = osw_stat_s'(sync2_reg[8:0]);
  wire logic new_tick = stat_sync.new_src_tick & ~tick_d_reg;
  wire logic init_load = (init_cnt_reg == 2'h2);
  wire logic init_done = (init_cnt_reg == 2'h3);

  // configuration decode
  wire logic switch_allowed = init_done & ~cfg_sync.switch_monitor_config[1];
  wire logic monitor_on = init_done & (cfg_sync.switch_monitor_config == MON_ON);
  wire logic frozen = monitor_on & sel_lock_reg;
  wire logic low_power_rc_keep = stat_sync.wdt_uses_low_power_rc | monitor_on;

  // bus decode
  wire logic apb_setup = psel & ~penable;
  wire logic apb_done = psel & penable & pready_reg;
  wire logic wr_done = apb_done & pwrite;
  wire logic hit_osc = (paddr == OFF_OSC_CTRL);
  wire logic hit_div = (paddr == OFF_CLK_DIV);
  wire logic hit_tun = (paddr == OFF_RC_TUNE);
  wire logic hit_any = hit_osc | hit_div | hit_tun;
  wire logic osc_wr_hi = wr_done & hit_osc & pstrb[1];
  wire logic osc_wr_lo = wr_done & hit_osc & pstrb[0];
  wire logic div_wr = wr_done & hit_div & pstrb[1];
  wire logic tun_wr = wr_done & hit_tun & pstrb[0];
  wire logic [7:0] wr_hi_byte = pwdata[15:8];
  wire logic [7:0] wr_lo_byte = pwdata[7:0];
  wire logic hi_apply = osc_wr_hi & (unl_hi_reg == UNL_ARMED);
  wire logic lo_apply = osc_wr_lo & (unl_lo_reg == UNL_ARMED);

  // switch start and source readiness
  wire logic sw_start = lo_apply & wr_lo_byte[SW_REQ_BIT] & switch_allowed
    & ~frozen & ~sw_req_reg;
  wire osw_oscmask_t need_mask = osw_src_mask(requested_reg);
  wire osw_oscmask_t act_mask = osw_src_mask(active_reg);
  wire logic need_pll = osw_src_pll(requested_reg);
  wire logic need_ost = need_mask[3] & (submode_reg != SUBMODE_EC);
  wire logic src_ready = ((need_mask & ~stat_sync.osc_running) == 4'h0)
    & (~need_ost | stat_sync.ost_done) & (~need_pll | pll_lock_reg);

  // old source drops out once active_reg takes the new source on done, unless a keep term holds it
  wire osw_oscmask_t keep_mask = {1'b0, secondary_osc_en_reg, low_power_rc_keep, 1'b0};
  wire osw_oscmask_t osc_en_next = act_mask | (sw_busy ? need_mask : 4'h0) | keep_mask;
  wire logic pll_en_next = osw_src_pll(active_reg) | (sw_busy & need_pll);

  // doze divider
  wire logic [2:0] eff_ratio = doze_act_reg ? doze_ratio_reg : 3'h0;
  wire logic [7:0] ratio_span = 8'h01 << eff_ratio;
  wire logic [6:0] ratio_mask = 7'(ratio_span - 8'h01);

  // read mux
  wire logic [31:0] rd_osc = {16'h0000, 1'b0, active_reg, 1'b0, requested_reg,
    sel_lock_reg, 1'b0, pll_lock_reg, 1'b0, fail_reg, 1'b0, secondary_osc_en_reg, sw_req_reg};
  wire logic [31:0] rd_div = {16'h0000, roi_reg, doze_ratio_reg, doze_act_reg,
    post_reg, 8'h00};
  wire logic [31:0] rd_tun = {16'h0000, 10'h000, trim_reg};
  wire logic [31:0] rd_sel = hit_osc ? rd_osc :
    hit_div ? rd_div :
    hit_tun ? rd_tun : 32'h0000_0000;

  function automatic osw_unlock_e unl_next(
    input osw_unlock_e cur,
    input logic wr,
    input logic other_wr,
    input logic [7:0] d,
    input logic [7:0] k1,
    input logic [7:0] k2
  );
    if (wr) begin
      if (cur == UNL_ARMED) return UNL_NONE;
      if (d == k1) return UNL_HALF;
      if (cur == UNL_HALF && d == k2) return UNL_ARMED;
      return UNL_NONE;
    end
    // any other write breaks the back-to-back pair
    if (other_wr) return UNL_NONE;
    return cur;
  endfunction : unl_next

  osw_switch_seq #(
    .SETTLE(SETTLE)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(sw_start),
    .req_src(requested_reg),
    .act_src(active_reg),
    .src_ready(src_ready),
    .tick(new_tick),
    .busy(sw_busy),
    .begin_p(sw_begin),
    .abort_p(sw_abort),
    .done_p(sw_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tick_d_reg <= 1'b0;
      init_cnt_reg <= 2'h0;
    end else begin
      sync1_reg <= {cfg_pins, osc_status};
      sync2_reg <= sync1_reg;
      tick_d_reg <= stat_sync.new_src_tick;
      if (!init_done) init_cnt_reg <= init_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (apb_setup) pready_reg <= 1'b1;
      else if (apb_done) pready_reg <= 1'b0;
      if (apb_setup) pslverr_reg <= ~hit_any;
      if (apb_setup) prdata_reg <= pwrite ? 32'h0000_0000 : rd_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_hi_reg <= UNL_NONE;
      unl_lo_reg <= UNL_NONE;
    end else begin
      unl_hi_reg <= unl_next(unl_hi_reg, osc_wr_hi, wr_done, wr_hi_byte,
        KEY_HI_1, KEY_HI_2);
      unl_lo_reg <= unl_next(unl_lo_reg, osc_wr_lo, wr_done, wr_lo_byte,
        KEY_LO_1, KEY_LO_2);
    end
  end

  // source fields; config is only valid after the synchroniser fills
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= SRC_RST;
      requested_reg <= SRC_RST;
      submode_reg <= SUBMODE_EC;
    end else begin
      if (init_load || (init_done && !switch_allowed)) begin
        active_reg <= cfg_sync.initial_source_config;
      end else if (sw_done) begin
        active_reg <= requested_reg;
      end
      if (init_load) begin
        requested_reg <= cfg_sync.initial_source_config;
      end else if (hi_apply && !frozen && !sw_req_reg) begin
        requested_reg <= wr_hi_byte[REQ_LSB-8 +: 3];
      end
      if (init_load) submode_reg <= cfg_sync.primary_submode_config;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lock_reg <= 1'b0;
      pll_lock_reg <= 1'b0;
      fail_reg <= 1'b0;
      secondary_osc_en_reg <= 1'b0;
      sw_req_reg <= 1'b0;
    end else begin
      if (lo_apply && wr_lo_byte[SEL_LOCK_BIT] && monitor_on) sel_lock_reg <= 1'b1;
      pll_lock_reg <= ~sw_begin & pll_en_reg & stat_sync.pll_locked;
      // detection wins over both software clear and switch clear
      fail_reg <= (monitor_on & stat_sync.clk_fail)
        | (fail_reg & ~sw_begin & ~(lo_apply & ~wr_lo_byte[FAIL_BIT]));
      if (lo_apply) secondary_osc_en_reg <= wr_lo_byte[SECONDARY_OSC_EN_BIT];
      if (!switch_allowed) sw_req_reg <= 1'b0;
      else if (sw_abort || sw_done) sw_req_reg <= 1'b0;
      else if (sw_start) sw_req_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roi_reg <= 1'b0;
      doze_ratio_reg <= DOZE_RST;
      doze_act_reg <= 1'b0;
      post_reg <= POST_RST;
      trim_reg <= TRIM_RST;
    end else begin
      if (div_wr) roi_reg <= pwdata[ROI_BIT];
      if (div_wr) doze_ratio_reg <= pwdata[DOZE_LSB +: 3];
      if (div_wr) post_reg <= pwdata[POST_LSB +: 3];
      // the interrupt wins over a same-cycle software set
      if (irq_event && roi_reg) doze_act_reg <= 1'b0;
      else if (div_wr) doze_act_reg <= pwdata[DOZE_EN_BIT];
      if (tun_wr) trim_reg <= pwdata[TRIM_LSB +: 6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_reg <= 4'h0;
      pll_en_reg <= 1'b0;
      ratio_out_reg <= 3'h0;
      cpu_en_reg <= 1'b0;
      div_cnt_reg <= 7'h00;
    end else begin
      osc_en_reg <= osc_en_next;
      pll_en_reg <= pll_en_next;
      ratio_out_reg <= eff_ratio;
      div_cnt_reg <= div_cnt_reg + 7'h01;
      cpu_en_reg <= ((div_cnt_reg & ratio_mask) == 7'h00);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign osc_ctl = '{
    osc_en: osc_en_reg,
    pll_en: pll_en_reg,
    sys_src: active_reg,
    primary_submode: submode_reg,
    cpu_ratio: ratio_out_reg,
    cpu_clk_en: cpu_en_reg,
    rc_postscaler: post_reg,
    rc_trim: trim_reg
  };

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_switch_done;
    sw_done ##1 1'b1;
  endsequence

  a_active_only_on_done: assert property ($changed(active_reg) |-> $past(sw_done)
    || $past(init_load) || $past(!switch_allowed))
    else $error("active source changed without a completed switch");
  a_req_needs_unlock: assert property ($changed(requested_reg) && !$past(init_load)
    |-> $past(unl_hi_reg) == UNL_ARMED && $past(osc_wr_hi))
    else $error("requested source written without unlock");
  a_lo_needs_unlock: assert property ($rose(secondary_osc_en_reg) || $rose(sw_req_reg)
    |-> $past(unl_lo_reg) == UNL_ARMED)
    else $error("low byte written without unlock");
  a_frozen_no_start: assert property ($rose(sw_req_reg) |-> $past(!frozen))
    else $error("switch started while selection locked");
  a_begin_clears_lock: assert property (sw_begin && !(monitor_on && stat_sync.clk_fail)
    |=> !pll_lock_reg && !fail_reg)
    else $error("switch start did not clear lock and fail");
  a_fail_sets: assert property (monitor_on && stat_sync.clk_fail |=> fail_reg)
    else $error("clock failure not flagged");
  a_lock_needs_pll: assert property (pll_lock_reg |-> $past(pll_en_reg)
    && $past(stat_sync.pll_locked))
    else $error("lock status without running pll");
  a_disabled_no_req: assert property (!switch_allowed |=> !sw_req_reg)
    else $error("switch request set while switching disabled");
  a_abort_keeps: assert property (sw_abort |=> !sw_req_reg && $stable(active_reg))
    else $error("redundant switch not aborted cleanly");
  a_done_copies: assert property (s_switch_done |-> !sw_req_reg
    && active_reg == $past(requested_reg))
    else $error("switch completion did not copy source");
  a_roi_clears: assert property (irq_event && roi_reg |=> !doze_act_reg)
    else $error("interrupt did not clear doze enable");
  a_ratio_off: assert property (!doze_act_reg |=> ratio_out_reg == 3'h0)
    else $error("cpu ratio applied while doze off");
  a_secondary_osc_kept: assert property (secondary_osc_en_reg |=> osc_ctl.osc_en[2])
    else $error("secondary oscillator stopped while enabled");
endmodule : osw_ctrl

// *** hdl/osw_pkg.sv ***
package osw_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_OSC_CTRL = 12'h000;
  localparam logic [11:0] OFF_CLK_DIV = 12'h004;
  localparam logic [11:0] OFF_RC_TUNE = 12'h008;
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  localparam int ACT_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int SEL_LOCK_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SECONDARY_OSC_EN_BIT = 1;
  localparam int SW_REQ_BIT = 0;
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int DOZE_EN_BIT = 11;
  localparam int POST_LSB = 8;
  localparam int TRIM_LSB = 0;
  localparam logic [2:0] DOZE_RST = 3'h3;
  localparam logic [2:0] POST_RST = 3'h0;
  localparam logic [2:0] SRC_RST = 3'h7;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [1:0] SUBMODE_EC = 2'h0;
  localparam logic [1:0] MON_ON = 2'h0;
  localparam int SETTLE_TICKS = 10;

  typedef enum logic [2:0] {
    SRC_FRC = 3'b000,
    SRC_FRC_PLL = 3'b001,
    SRC_PRI = 3'b010,
    SRC_PRI_PLL = 3'b011,
    SRC_SEC = 3'b100,
    SRC_LOW_POWER_RC = 3'b101,
    SRC_LP_FRC_DIV = 3'b110,
    SRC_FRC_DIV = 3'b111
  } osw_src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SETTLE = 2'b10
  } osw_state_e;

  typedef enum logic [1:0] {
    UNL_NONE = 2'b00,
    UNL_HALF = 2'b01,
    UNL_ARMED = 2'b10
  } osw_unlock_e;

  // {primary, secondary, low_power_rc, fast_rc}
  typedef logic [3:0] osw_oscmask_t;

  typedef struct packed {
    logic [1:0] switch_monitor_config;
    logic [2:0] initial_source_config;
    logic [1:0] primary_submode_config;
  } osw_cfg_s;

  typedef struct packed {
    logic [3:0] osc_running;
    logic ost_done;
    logic pll_locked;
    logic clk_fail;
    logic new_src_tick;
    logic wdt_uses_low_power_rc;
  } osw_stat_s;

  typedef struct packed {
    osw_oscmask_t osc_en;
    logic pll_en;
    logic [2:0] sys_src;
    logic [1:0] primary_submode;
    logic [2:0] cpu_ratio;
    logic cpu_clk_en;
    logic [2:0] rc_postscaler;
    logic [5:0] rc_trim;
  } osw_ctl_s;

  function automatic osw_oscmask_t osw_src_mask(input logic [2:0] src);
    case (osw_src_e'(src))
      SRC_PRI, SRC_PRI_PLL: return 4'h8;
      SRC_SEC: return 4'h4;
      SRC_LOW_POWER_RC: return 4'h2;
      default: return 4'h1;
    endcase
  endfunction : osw_src_mask

  function automatic logic osw_src_pll(input logic [2:0] src);
    return (src == SRC_PRI_PLL) || (src == SRC_FRC_PLL);
  endfunction : osw_src_pll
endpackage : osw_pkg

// *** hdl/osw_switch_seq.sv ***
`timescale 1ns/100ps
module osw_switch_seq #(
  parameter int SETTLE = osw_pkg::SETTLE_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [2:0] req_src,
  input wire logic [2:0] act_src,
  input wire logic src_ready,
  input wire logic tick,
  output logic busy,
  output logic begin_p,
  output logic abort_p,
  output logic done_p
);
  import osw_pkg::*;
  localparam int CW = $clog2(SETTLE + 1);

  osw_state_e st_reg;
  osw_state_e st_next;
  logic [CW-1:0] cnt_reg;
  wire logic same_src = (req_src == act_src);
  wire logic go_idle = (st_reg == ST_IDLE) & start;
  wire logic last_tick = (st_reg == ST_SETTLE) & tick & (cnt_reg == CW'(SETTLE - 1));

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: if (start && !same_src) st_next = ST_WAIT;
      ST_WAIT: if (src_ready) st_next = ST_SETTLE;
      ST_SETTLE: if (last_tick) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
      begin_p <= 1'b0;
      abort_p <= 1'b0;
      done_p <= 1'b0;
    end else begin
      st_reg <= st_next;
      // counts edges of the new source, not pclk
      if (st_reg != ST_SETTLE) cnt_reg <= '0;
      else if (tick) cnt_reg <= cnt_reg + 1'b1;
      begin_p <= go_idle & ~same_src;
      abort_p <= go_idle & same_src;
      done_p <= last_tick;
    end
  end

  assign busy = (st_reg != ST_IDLE);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ready_seen;
    st_reg == ST_WAIT && src_ready;
  endsequence

  a_settle_ten_ticks: assert property (done_p |-> $past(cnt_reg) == CW'(SETTLE - 1)
    && $past(tick) && $past(st_reg) == ST_SETTLE)
    else $error("switch done without ten new-clock ticks");
  a_wait_for_ready: assert property (st_reg == ST_WAIT && !src_ready |=> st_reg == ST_WAIT)
    else $error("left wait before new source ready");
  a_ready_to_settle: assert property (s_ready_seen |=> st_reg == ST_SETTLE && cnt_reg == 0)
    else $error("ready source did not start settle count");
  a_equal_abort: assert property (go_idle && same_src |=> abort_p && !begin_p && !busy)
    else $error("redundant switch not aborted");
endmodule : osw_switch_seq

// *** testbench/test_osw_ctrl.sv ***
`timescale 1ns/100ps
module test_osw_ctrl;
  import osw_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  osw_cfg_s cfg = {2'b00, 3'b111, 2'b00};
  osw_stat_s stat = {4'hf, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic irq_event = 1'b0;
  osw_ctl_s osc_ctl;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  int t0;

  osw_ctrl #(.SETTLE(SETTLE_TICKS)) u_osw_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_pins(cfg), .osc_status(stat), .irq_event(irq_event),
    .osc_ctl(osc_ctl)
  );

  always #25 pclk = ~pclk;

  // new source clock: period of 8 pclk cycles, well below pclk/4
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) begin
      stat.new_src_tick <= ~stat.new_src_tick;
    end
  end

  task tally_and_finish;
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready and read data are taken at the rising edge that completes the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      num_errors++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, exp);
  endtask : rd_chk

  // hi: upper-byte key pair then value on lane 1; else lower byte on lane 0
  task unl_wr(input logic hi, input logic [7:0] v);
    if (hi) begin
      xfer(1'b1, OFF_OSC_CTRL, {16'h0000, KEY_HI_1, 8'h00}, 4'b0010);
      xfer(1'b1, OFF_OSC_CTRL, {16'h0000, KEY_HI_2, 8'h00}, 4'b0010);
      xfer(1'b1, OFF_OSC_CTRL, {16'h0000, v, 8'h00}, 4'b0010);
    end else begin
      xfer(1'b1, OFF_OSC_CTRL, {24'h00_0000, KEY_LO_1}, 4'b0001);
      xfer(1'b1, OFF_OSC_CTRL, {24'h00_0000, KEY_LO_2}, 4'b0001);
      xfer(1'b1, OFF_OSC_CTRL, {24'h00_0000, v}, 4'b0001);
    end
  endtask : unl_wr

  // polls until the request bit drops; leaves elapsed cycles in t0
  task wait_sw;
    int n;
    n = 0;
    t0 = cyc;
    do begin
      xfer(1'b0, OFF_OSC_CTRL, 32'h0000_0000, 4'h0);
      n++;
    end while (rd[SW_REQ_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
    end
    t0 = cyc - t0;
  endtask : wait_sw

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask : do_reset

  task t_reset_regs;
    rd_chk(OFF_OSC_CTRL, 32'h0000_7700);
    rd_chk(OFF_CLK_DIV, 32'h0000_3000);
    rd_chk(OFF_RC_TUNE, 32'h0000_0000);
    xfer(1'b0, 12'h00c, 32'h0000_0000, 4'h0);
    chk({31'h0, er}, 32'h0000_0001);
  endtask : t_reset_regs

  task t_no_unlock;
    xfer(1'b1, OFF_OSC_CTRL, 32'h0000_0200, 4'b0010);
    rd_chk(OFF_OSC_CTRL, 32'h0000_7700);
    xfer(1'b1, OFF_OSC_CTRL, {16'h0000, KEY_HI_1, 8'h00}, 4'b0010);
    xfer(1'b1, OFF_OSC_CTRL, 32'h0000_1200, 4'b0010);
    xfer(1'b1, OFF_OSC_CTRL, 32'h0000_0200, 4'b0010);
    rd_chk(OFF_OSC_CTRL, 32'h0000_7700);
  endtask : t_no_unlock

  task t_switch_primary;
    unl_wr(1'b1, 8'h02);
    rd_chk(OFF_OSC_CTRL, 32'h0000_7200);
    unl_wr(1'b0, 8'h01);
    wait_sw();
    chk({31'h0, t0 >= 9 * 8}, 32'h0000_0001);
    chk(rd, 32'h0000_2200);
    chk({29'h0, osc_ctl.sys_src}, {29'h0, SRC_PRI});
  endtask : t_switch_primary

  task t_fail_and_back;
    @(posedge pclk);
    stat.clk_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    stat.clk_fail <= 1'b0;
    rd_chk(OFF_OSC_CTRL, 32'h0000_2208);
    unl_wr(1'b1, 8'h00);
    unl_wr(1'b0, 8'h03);
    wait_sw();
    chk(rd, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({30'h0, osc_ctl.osc_en[3:2]}, 32'h0000_0001);
    unl_wr(1'b0, 8'h03);
    wait_sw();
    chk({31'h0, t0 < 20}, 32'h0000_0001);
    chk(rd, 32'h0000_0002);
  endtask : t_fail_and_back

  // fast rc to its pll mode and back; the way back lands on plain fast rc
  task t_pll;
    unl_wr(1'b1, 8'h01);
    unl_wr(1'b0, 8'h03);
    repeat (40) @(posedge pclk);
    rd_chk(OFF_OSC_CTRL, 32'h0000_0103);
    chk({31'h0, osc_ctl.pll_en}, 32'h0000_0001);
    @(posedge pclk);
    stat.pll_locked <= 1'b1;
    wait_sw();
    rd_chk(OFF_OSC_CTRL, 32'h0000_1122);
    unl_wr(1'b1, 8'h00);
    unl_wr(1'b0, 8'h03);
    wait_sw();
    repeat (3) @(posedge pclk);
    rd_chk(OFF_OSC_CTRL, 32'h0000_0002);
    chk({31'h0, osc_ctl.pll_en}, 32'h0000_0000);
    @(posedge pclk);
    stat.pll_locked <= 1'b0;
  endtask : t_pll

  task t_lock;
    unl_wr(1'b0, 8'h82);
    unl_wr(1'b1, 8'h02);
    rd_chk(OFF_OSC_CTRL, 32'h0000_0082);
    unl_wr(1'b0, 8'h83);
    rd_chk(OFF_OSC_CTRL, 32'h0000_0082);
  endtask : t_lock

  task t_doze_trim;
    int k;
    k = 0;
    xfer(1'b1, OFF_CLK_DIV, 32'h0000_cd00, 4'b0010);
    rd_chk(OFF_CLK_DIV, 32'h0000_cd00);
    chk({29'h0, osc_ctl.cpu_ratio}, 32'h0000_0004);
    chk({29'h0, osc_ctl.rc_postscaler}, 32'h0000_0005);
    repeat (32) begin
      @(posedge pclk);
      k += osc_ctl.cpu_clk_en;
    end
    chk(k, 32'h0000_0002);
    @(posedge pclk);
    irq_event <= 1'b1;
    @(posedge pclk);
    irq_event <= 1'b0;
    rd_chk(OFF_CLK_DIV, 32'h0000_c500);
    chk({29'h0, osc_ctl.cpu_ratio}, 32'h0000_0000);
    k = 0;
    repeat (16) begin
      @(posedge pclk);
      k += osc_ctl.cpu_clk_en;
    end
    chk(k, 32'h0000_0010);
    xfer(1'b1, OFF_RC_TUNE, 32'h0000_00ff, 4'b0001);
    rd_chk(OFF_RC_TUNE, 32'h0000_003f);
    chk({26'h0, osc_ctl.rc_trim}, 32'h0000_003f);
  endtask : t_doze_trim

  task t_disabled;
    cfg <= {2'b10, 3'b101, 2'b01};
    do_reset();
    rd_chk(OFF_OSC_CTRL, 32'h0000_5500);
    unl_wr(1'b0, 8'h01);
    rd_chk(OFF_OSC_CTRL, 32'h0000_5500);
    chk({29'h0, osc_ctl.sys_src}, {29'h0, SRC_LOW_POWER_RC});
    chk({30'h0, osc_ctl.primary_submode}, 32'h0000_0001);
  endtask : t_disabled

  initial begin
    do_reset();
    t_reset_regs();
    t_no_unlock();
    t_switch_primary();
    t_fail_and_back();
    t_pll();
    t_lock();
    t_doze_trim();
    t_disabled();
    tally_and_finish();
  end

  // the whole run takes well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule : test_osw_ctrl
